// File: pgb_pkg.sv
package pgb_pkg;
  // ----------------------------------------------------------------
  // register file addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PGB_ADDR_DATA = 8'h06;
  localparam logic [7:0] PGB_ADDR_INTCTL = 8'h0b;
  localparam logic [7:0] PGB_ADDR_OPTION = 8'h81;
  localparam logic [7:0] PGB_ADDR_DIR = 8'h86;
  localparam logic [7:0] PGB_ADDR_INTCTL_HI = 8'h8b;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PGB_OPT_PULLUP_DIS_N = 7;
  localparam int PGB_OPT_EDGE_SEL = 6;
  localparam int PGB_ICW_GLOBAL_EN = 7;
  localparam int PGB_ICW_EXT_EN = 4;
  localparam int PGB_ICW_CHANGE_EN = 3;
  localparam int PGB_ICW_EXT_FLAG = 1;
  localparam int PGB_ICW_CHANGE_FLAG = 0;
  localparam int PGB_CHANGE_LO = 4;
  localparam int PGB_EXT_PIN = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PGB_RST_OPTION = 8'hff;
  localparam logic [7:0] PGB_RST_DIR = 8'hff;
  localparam logic [7:0] PGB_RST_LATCH = 8'h00;
  localparam logic [7:0] PGB_RST_ICW = 8'h00;

  // register file access from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pgb_acc_s;

  // pin-side signals toward the pad ring
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pullup_en;
  } pgb_pad_s;
endpackage

// File: pgb_port.sv
`timescale 1ns/1ps
module pgb_port
  import pgb_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire pgb_acc_s acc,
  input wire logic [WIDTH-1:0] pin_in,
  output pgb_pad_s pad_q,
  output logic [7:0] rdata_q,
  output logic irq_q,
  output logic wake_q
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (WIDTH != 8) begin : g_bad_width
    $error("pgb_port supports only an eight bit port");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] option_q;
  logic [7:0] icw_q;
  logic [3:0] snap_q;
  logic ext_prev_q;

  logic rd_data, wr_data, wr_icw, access_data;
  logic [3:0] mismatch;
  logic change_set, ext_edge;

  function automatic logic hit(input pgb_acc_s a, input logic [7:0] addr);
    return a.addr == addr;
  endfunction

  assign rd_data = acc.rd && hit(acc, PGB_ADDR_DATA);
  assign wr_data = acc.wr && hit(acc, PGB_ADDR_DATA);
  // the control word is mirrored in both banks
  assign wr_icw = acc.wr && (hit(acc, PGB_ADDR_INTCTL) || hit(acc, PGB_ADDR_INTCTL_HI));
  assign access_data = rd_data || wr_data;

  // ----------------------------------------------------------------
  // change detection
  // ----------------------------------------------------------------
  // upper inputs only
  assign mismatch = (pin_in[7:PGB_CHANGE_LO] ^ snap_q) & dir_q[7:PGB_CHANGE_LO];
  assign change_set = |mismatch;

  assign ext_edge = option_q[PGB_OPT_EDGE_SEL] ? (pin_in[PGB_EXT_PIN] && !ext_prev_q)
                                               : (!pin_in[PGB_EXT_PIN] && ext_prev_q);

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // latch loads regardless of direction
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_q <= PGB_RST_LATCH;
    end else if (wr_data) begin
      latch_q <= acc.wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dir_q <= PGB_RST_DIR;
    end else if (acc.wr && hit(acc, PGB_ADDR_DIR)) begin
      dir_q <= acc.wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      option_q <= PGB_RST_OPTION;
    end else if (acc.wr && hit(acc, PGB_ADDR_OPTION)) begin
      option_q <= acc.wdata;
    end
  end

  // snapshot refreshed on any data register access
  // a write refreshes from the pins, not the written value: an output pin is masked anyway
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      snap_q <= 4'h0;
    end else if (access_data) begin
      snap_q <= pin_in[7:PGB_CHANGE_LO];
    end
  end

  // resets high: with the default rising select a pin held high at release is no edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ext_prev_q <= 1'b1;
    end else begin
      ext_prev_q <= pin_in[PGB_EXT_PIN];
    end
  end

  // ----------------------------------------------------------------
  // interrupt control word
  // ----------------------------------------------------------------
  // set wins over clear while mismatch lasts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      icw_q <= PGB_RST_ICW;
    end else begin
      if (wr_icw) begin
        icw_q <= acc.wdata;
      end
      // the access that ends a mismatch still sets the flag this cycle
      if (change_set) begin
        icw_q[PGB_ICW_CHANGE_FLAG] <= 1'b1;
      end
      if (ext_edge) begin
        icw_q[PGB_ICW_EXT_FLAG] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // input pins undriven
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_q.out <= PGB_RST_LATCH;
      pad_q.oe_n <= PGB_RST_DIR;
      pad_q.pullup_en <= 8'h00;
    end else begin
      pad_q.out <= latch_q;
      pad_q.oe_n <= dir_q;
      pad_q.pullup_en <= dir_q & {8{!option_q[PGB_OPT_PULLUP_DIS_N]}};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (acc.rd) begin
      unique case (acc.addr)
        PGB_ADDR_DATA: rdata_q <= pin_in;
        PGB_ADDR_INTCTL, PGB_ADDR_INTCTL_HI: rdata_q <= icw_q;
        PGB_ADDR_OPTION: rdata_q <= option_q;
        PGB_ADDR_DIR: rdata_q <= dir_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      irq_q <= icw_q[PGB_ICW_GLOBAL_EN] &&
               ((icw_q[PGB_ICW_CHANGE_FLAG] && icw_q[PGB_ICW_CHANGE_EN]) ||
                (icw_q[PGB_ICW_EXT_FLAG] && icw_q[PGB_ICW_EXT_EN]));
      wake_q <= icw_q[PGB_ICW_CHANGE_FLAG] && icw_q[PGB_ICW_CHANGE_EN];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_flag_on_mismatch;
    @(posedge clk) disable iff (!reset_n) change_set |=> icw_q[PGB_ICW_CHANGE_FLAG];
  endproperty
  a_flag_on_mismatch: assert property (p_flag_on_mismatch)
    else $error("change flag not set after mismatch");

  property p_outputs_masked;
    @(posedge clk) disable iff (!reset_n)
      (pin_in[7:4] != snap_q) && (dir_q[7:4] == 4'h0) && !wr_icw
        && !icw_q[PGB_ICW_CHANGE_FLAG] |=> !icw_q[PGB_ICW_CHANGE_FLAG];
  endproperty
  a_outputs_masked: assert property (p_outputs_masked)
    else $error("output pin caused change flag");

  property p_snap_refresh;
    @(posedge clk) disable iff (!reset_n) access_data |=> snap_q == $past(pin_in[7:4]);
  endproperty
  a_snap_refresh: assert property (p_snap_refresh)
    else $error("snapshot not refreshed on data access");

  property p_sticky;
    @(posedge clk) disable iff (!reset_n)
      icw_q[PGB_ICW_CHANGE_FLAG] && !wr_icw |=> icw_q[PGB_ICW_CHANGE_FLAG];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("change flag dropped without a write");

  property p_pad_drive;
    @(posedge clk) disable iff (!reset_n) 1'b1 |=> pad_q.oe_n == $past(dir_q);
  endproperty
  a_pad_drive: assert property (p_pad_drive)
    else $error("driver enable does not follow direction");

  property p_pad_value;
    @(posedge clk) disable iff (!reset_n) wr_data |=> ##1 pad_q.out == $past(acc.wdata, 2);
  endproperty
  a_pad_value: assert property (p_pad_value)
    else $error("pin output does not follow latch");

  property p_no_pullup_out;
    @(posedge clk) disable iff (!reset_n) (pad_q.pullup_en & ~pad_q.oe_n) == 8'h00;
  endproperty
  a_no_pullup_out: assert property (p_no_pullup_out)
    else $error("pull-up on output pin");

  property p_pullup_ctl;
    @(posedge clk) disable iff (!reset_n)
      option_q[PGB_OPT_PULLUP_DIS_N] |=> pad_q.pullup_en == 8'h00;
  endproperty
  a_pullup_ctl: assert property (p_pullup_ctl)
    else $error("pull-up on while disabled");

  property p_ext_edge;
    @(posedge clk) disable iff (!reset_n)
      option_q[PGB_OPT_EDGE_SEL] && $rose(pin_in[0]) |=> icw_q[PGB_ICW_EXT_FLAG];
  endproperty
  a_ext_edge: assert property (p_ext_edge)
    else $error("rising edge missed on external pin");

  property p_wake;
    @(posedge clk) disable iff (!reset_n)
      icw_q[PGB_ICW_CHANGE_FLAG] && icw_q[PGB_ICW_CHANGE_EN] |=> wake_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake not raised");

  property p_read_pins;
    @(posedge clk) disable iff (!reset_n) rd_data |=> rdata_q == $past(pin_in);
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("data read does not return pin levels");

  property p_irq_gate;
    @(posedge clk) disable iff (!reset_n)
      !icw_q[PGB_ICW_GLOBAL_EN] |=> !irq_q;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("request raised without global enable");

  property p_ext_fall;
    @(posedge clk) disable iff (!reset_n)
      !option_q[PGB_OPT_EDGE_SEL] && $fell(pin_in[0]) |=> icw_q[PGB_ICW_EXT_FLAG];
  endproperty
  a_ext_fall: assert property (p_ext_fall)
    else $error("falling edge missed on external pin");

  property p_flag_clear;
    @(posedge clk) disable iff (!reset_n)
      wr_icw && !acc.wdata[PGB_ICW_CHANGE_FLAG] && !change_set
        |=> !icw_q[PGB_ICW_CHANGE_FLAG];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("change flag not cleared by write");

  property p_latch_load;
    @(posedge clk) disable iff (!reset_n) wr_data |=> latch_q == $past(acc.wdata);
  endproperty
  a_latch_load: assert property (p_latch_load)
    else $error("output latch not loaded by write");

  c_change: cover property (@(posedge clk) disable iff (!reset_n) change_set ##1 irq_q);
  c_clear: cover property (@(posedge clk) disable iff (!reset_n)
    access_data ##1 wr_icw ##1 !icw_q[PGB_ICW_CHANGE_FLAG]);
  c_ext: cover property (@(posedge clk) disable iff (!reset_n) ext_edge);
  c_wake_only: cover property (@(posedge clk) disable iff (!reset_n) wake_q && !irq_q);
  c_masked: cover property (@(posedge clk) disable iff (!reset_n)
    (dir_q[7:4] == 4'h0) && (pin_in[7:4] != snap_q));

endmodule // pgb_port

// File: pgb_keypad.sv
`timescale 1ns/1ps
module pgb_keypad
  import pgb_pkg::*;
(
  input wire logic clk,
  input wire pgb_pad_s pad_q,
  input wire logic [7:0] key_en,
  input wire logic [7:0] key_val,
  output logic [7:0] pins
);
  logic [7:0] float_q = 8'h55;
  // a line nobody holds wanders, so a stale level never passes for data
  always @(posedge clk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_q.oe_n[i]) pins[i] = pad_q.out[i];
      else if (key_en[i]) pins[i] = key_val[i];
      else if (pad_q.pullup_en[i]) pins[i] = 1'b1;
      else pins[i] = float_q[i];
    end
  end
endmodule // pgb_keypad

// File: pgb_tb.sv
`timescale 1ns/1ps
module testbench
  import pgb_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  pgb_acc_s acc = '0;
  logic [7:0] pin_in;
  logic [7:0] key_en = 8'hff;
  logic [7:0] key_val = 8'h00;
  pgb_pad_s pad_q;
  logic [7:0] rdata_q;
  logic irq_q;
  logic wake_q;
  logic rd_seen = 1'b0;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 8011;
  int cyc = 0;
  logic [7:0] exp_q[$];
  logic [7:0] w;
  logic [7:0] d;
  logic [7:0] k;

  initial forever #2 clk = ~clk;

  pgb_port DUT (.clk(clk), .reset_n(reset_n), .acc(acc), .pin_in(pin_in),
    .pad_q(pad_q), .rdata_q(rdata_q), .irq_q(irq_q), .wake_q(wake_q));
  pgb_keypad keys (.clk(clk), .pad_q(pad_q), .key_en(key_en),
    .key_val(key_val), .pins(pin_in));

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task acc_op(input logic r, input logic wr, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    acc <= '{rd: r, wr: wr, addr: a, wdata: v};
    @(posedge clk);
    acc <= '0;
  endtask

  task wr8(input logic [7:0] a, input logic [7:0] v);
    acc_op(1'b0, 1'b1, a, v);
  endtask

  task rd8(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc_op(1'b1, 1'b0, a, 8'h00);
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // read monitor: read data stands the cycle after the strobe
  // ------------------------------------------------------------
  always @(posedge clk) rd_seen <= acc.rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) chk(8'h00, 8'hff);
      else chk(rdata_q, exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    tick(8);
    reset_n <= 1'b1;
    tick(1);
    chk(pad_q.out, PGB_RST_LATCH);
    chk(pad_q.oe_n, 8'hff);
    chk(pad_q.pullup_en, 8'h00);
    chk({6'h00, irq_q, wake_q}, 8'h00);
    rd8(PGB_ADDR_OPTION, PGB_RST_OPTION);
    rd8(PGB_ADDR_DIR, PGB_RST_DIR);
    rd8(PGB_ADDR_INTCTL, PGB_RST_ICW);
    rd8(8'h05, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      w = 8'($random(seed));
      d = 8'($random(seed));
      k = 8'($random(seed));
      key_val <= k;
      wr8(PGB_ADDR_DATA, w);
      wr8(PGB_ADDR_DIR, d);
      tick(3);
      chk(pad_q.out, w);
      chk(pad_q.oe_n, d);
      rd8(PGB_ADDR_DATA, (w & ~d) | (k & d));
    end
    $display("direction test done");
    wr8(PGB_ADDR_OPTION, 8'h7f);
    tick(3);
    chk(pad_q.pullup_en, d);
    key_en <= 8'h00;
    rd8(PGB_ADDR_DATA, w | d);
    wr8(PGB_ADDR_OPTION, 8'hff);
    tick(3);
    chk(pad_q.pullup_en, 8'h00);
    key_en <= 8'hff;
    $display("pull-up test done");
    key_val <= 8'h00;
    wr8(PGB_ADDR_DIR, 8'hff);
    tick(2);
    // one read arms the compare, then no polling
    rd8(PGB_ADDR_DATA, 8'h00);
    wr8(PGB_ADDR_INTCTL, 8'h88);
    key_val <= 8'h0e;
    tick(3);
    rd8(PGB_ADDR_INTCTL, 8'h88);
    key_val <= 8'h2e;
    tick(3);
    chk({6'h00, irq_q, wake_q}, 8'h03);
    wr8(PGB_ADDR_INTCTL, 8'h88);
    rd8(PGB_ADDR_INTCTL_HI, 8'h89);
    rd8(PGB_ADDR_DATA, 8'h2e);
    wr8(PGB_ADDR_INTCTL, 8'h88);
    rd8(PGB_ADDR_INTCTL, 8'h88);
    chk({6'h00, irq_q, wake_q}, 8'h00);
    wr8(PGB_ADDR_DATA, 8'h00);
    wr8(PGB_ADDR_DIR, 8'h7f);
    tick(3);
    rd8(PGB_ADDR_DATA, 8'h2e);
    wr8(PGB_ADDR_DATA, 8'h80);
    tick(3);
    rd8(PGB_ADDR_INTCTL, 8'h88);
    wr8(PGB_ADDR_INTCTL, 8'h80);
    key_val <= 8'h6e;
    tick(3);
    chk({6'h00, irq_q, wake_q}, 8'h00);
    rd8(PGB_ADDR_INTCTL, 8'h81);
    $display("change test done");
    rd8(PGB_ADDR_DATA, 8'hee);
    wr8(PGB_ADDR_INTCTL, 8'h90);
    key_val <= 8'h6f;
    tick(3);
    chk({6'h00, irq_q, wake_q}, 8'h02);
    rd8(PGB_ADDR_INTCTL, 8'h92);
    wr8(PGB_ADDR_OPTION, 8'hbf);
    wr8(PGB_ADDR_INTCTL, 8'h90);
    rd8(PGB_ADDR_INTCTL, 8'h90);
    key_val <= 8'h6e;
    tick(3);
    rd8(PGB_ADDR_INTCTL, 8'h92);
    tick(2);
    $display("edge test done");
    wr8(PGB_ADDR_INTCTL, 8'h08);
    key_val <= 8'h2e;
    tick(3);
    chk({6'h00, irq_q, wake_q}, 8'h01);
    rd8(PGB_ADDR_INTCTL, 8'h09);
    wr8(PGB_ADDR_DIR, 8'h0f);
    tick(2);
    rd8(PGB_ADDR_DATA, 8'h8e);
    wr8(PGB_ADDR_INTCTL, 8'h08);
    wr8(PGB_ADDR_DATA, 8'h70);
    tick(3);
    rd8(PGB_ADDR_INTCTL, 8'h08);
    $display("wake test done");
    wr8(PGB_ADDR_OPTION, 8'h7f);
    tick(3);
    chk(pad_q.pullup_en, 8'h0f);
    reset_n <= 1'b0;
    tick(2);
    reset_n <= 1'b1;
    tick(1);
    chk(pad_q.pullup_en, 8'h00);
    chk(pad_q.oe_n, 8'hff);
    $display("second reset test done");
    conclude();
  end
endmodule // testbench
